// >>> hdl/csr_pkg.sv
// Package of offsets, field layouts, resets and decode constants for csr.
`default_nettype none
package csr_pkg;
    // Register offsets (printed offsets are not multiples of four: indices).
    localparam logic [3:0] CSR_IDX_CONV0_CTRL = 4'h3;
    localparam logic [3:0] CSR_IDX_CONV1_CTRL = 4'h5;
    localparam logic [3:0] CSR_IDX_CONV0_VSET = 4'h6;
    localparam logic [3:0] CSR_IDX_CONV1_VSET = 4'h7;
    // Field positions of the current and slew control register.
    localparam int CSR_ILIM_LSB = 3;
    localparam int CSR_ILIM_MSB = 5;
    localparam int CSR_SLEW_LSB = 0;
    localparam int CSR_SLEW_MSB = 2;
    localparam int CSR_RSVD_LSB = 6;
    localparam int CSR_RSVD_MSB = 7;
    // Reset values.
    localparam logic [7:0] CSR_CTRL_RESET = 8'h1a;
    localparam logic [7:0] CSR_VSET_RESET = 8'h00;
    // Current limit decode: milliamps, code 7 reserved.
    localparam logic [2:0] CSR_ILIM_RSVD = 3'h7;
    localparam logic [12:0] CSR_ILIM_BASE_MA = 13'h05dc;
    localparam logic [12:0] CSR_ILIM_STEP_MA = 13'h01f4;
    // Voltage code segment bounds and step sizes in millivolts.
    localparam logic [7:0] CSR_VSET_SEG1 = 8'h14;
    localparam logic [7:0] CSR_VSET_SEG2 = 8'h18;
    localparam logic [7:0] CSR_VSET_SEG3 = 8'h9e;
    localparam logic [11:0] CSR_SEG1_BASE_MV = 12'h2bc;
    localparam logic [11:0] CSR_SEG2_BASE_MV = 12'h2df;
    localparam logic [11:0] CSR_SEG3_BASE_MV = 12'h58c;
    localparam logic [11:0] CSR_SEG1_STEP_MV = 12'h00a;
    localparam logic [11:0] CSR_SEG2_STEP_MV = 12'h005;
    localparam logic [11:0] CSR_SEG3_STEP_MV = 12'h014;
    // AXI responses.
    localparam logic [1:0] CSR_RESP_OKAY = 2'h0;
    localparam logic [1:0] CSR_RESP_SLVERR = 2'h2;

    // Defaults loaded at initialisation from configuration memory.
    typedef struct packed {
        logic [7:0] conv0_ctrl;
        logic [7:0] conv1_ctrl;
        logic [7:0] conv0_vset;
        logic [7:0] conv1_vset;
    } csr_defaults_t;

    // Decoded setpoint for one converter.
    typedef struct packed {
        logic [12:0] ilim_ma;
        logic ilim_valid;
        logic [2:0] slew_code;
        logic slew_valid;
        logic [11:0] vout_mv;
        logic vout_valid;
    } csr_setpoint_t;

    // Loader states.
    typedef enum logic [1:0] {
        CSR_LD_IDLE = 2'b00,
        CSR_LD_LOAD = 2'b01,
        CSR_LD_DONE = 2'b10
    } csr_ld_state_t;
endpackage
`default_nettype wire

// >>> hdl/csr_decode.sv
// Decoder from register codes to physical setpoints for one converter.
`timescale 1ns/10ps
`default_nettype none
module csr_decode (
    // Register values.
    input wire logic [7:0] ctrl,
    input wire logic [7:0] vset,
    // Decoded setpoint.
    output csr_pkg::csr_setpoint_t setpoint
);
    import csr_pkg::*;

    // Field extraction.
    wire [2:0] ilim_code = ctrl[CSR_ILIM_MSB:CSR_ILIM_LSB];
    wire [2:0] slew_code = ctrl[CSR_SLEW_MSB:CSR_SLEW_LSB];
    // Segment selection of the voltage code.
    wire in_seg3 = vset >= CSR_VSET_SEG3;
    wire in_seg2 = !in_seg3 && vset >= CSR_VSET_SEG2;
    wire in_seg1 = !in_seg3 && !in_seg2 && vset >= CSR_VSET_SEG1;
    // Offsets within each segment.
    wire [11:0] off1 = {4'h0, vset - CSR_VSET_SEG1};
    wire [11:0] off2 = {4'h0, vset - CSR_VSET_SEG2};
    wire [11:0] off3 = {4'h0, vset - CSR_VSET_SEG3};
    wire [11:0] mv1 = 12'(CSR_SEG1_BASE_MV + off1 * CSR_SEG1_STEP_MV);
    wire [11:0] mv2 = 12'(CSR_SEG2_BASE_MV + off2 * CSR_SEG2_STEP_MV);
    wire [11:0] mv3 = 12'(CSR_SEG3_BASE_MV + off3 * CSR_SEG3_STEP_MV);

    // Current limit in 0.5 A steps from 1.5 A, code 7 reserved.
    assign setpoint.ilim_ma = 13'(CSR_ILIM_BASE_MA
        + {10'h000, ilim_code} * CSR_ILIM_STEP_MA);
    assign setpoint.ilim_valid = ilim_code != CSR_ILIM_RSVD;
    // Slew codes 0 and 1 are reserved; code applies to both ramp edges.
    assign setpoint.slew_code = slew_code;
    assign setpoint.slew_valid = slew_code[2] | slew_code[1];
    // Piecewise voltage target; low codes are flagged as reserved.
    assign setpoint.vout_mv = in_seg3 ? mv3 :
        in_seg2 ? mv2 :
        in_seg1 ? mv1 : 12'h000;
    assign setpoint.vout_valid = in_seg1 | in_seg2 | in_seg3;
endmodule // csr_decode
`default_nettype wire

// >>> hdl/csr_regs.sv
// AXI4-Lite register bank for two step-down converter setpoints.
// Register map, as byte addresses on the bus:
//   0x0c  converter a current and slew control.
//   0x14  converter b current and slew control.
//   0x18  converter a output voltage set code.
//   0x1c  converter b output voltage set code.
// Every register is one byte wide and sits in the low byte lane of
// an aligned 32-bit word. The upper 24 bits of read data are zero.
//
// Control register layout, the same for both converters:
//   bits 7..6  reserved, read-write, kept exactly as written.
//   bits 5..3  peak current limit code.
//   bits 2..0  output ramp speed code.
// The current limit code runs from 1.5 A at code 0 up to 4.5 A at
// code 6 in 0.5 A steps; code 7 is reserved. The ramp speed code
// applies to both rising and falling ramps; codes 0 and 1 are
// reserved. Reserved codes are stored as written, so a read shows
// what software wrote, and the decoder drops the matching valid
// flag so the analogue side can ignore them.
//
// Voltage set code segments:
//   codes below 0x14     reserved, shown as an invalid target.
//   0x14 .. 0x17         0.70 V upward in 10 mV steps.
//   0x18 .. 0x9d         0.735 V upward in 5 mV steps.
//   0x9e .. 0xff         1.42 V upward in 20 mV steps.
// Keeping reserved voltage codes out is left to the host. The
// register does not refuse them, because a refusal here would hide
// a host bug instead of exposing it on the valid flag.
//
// Write channel behaviour:
// The address and data halves are captured independently, each in
// its own one-entry hold slot, so a master may offer them together
// or in either order. Each ready is simply the inverse of the hold
// flag, which keeps the ready path free of any bus input. Once both
// halves are held and no response is pending, the write is done in
// one cycle and the response is raised on the next edge. The
// response stands until the master's ready is seen high.
// Only byte lane zero carries register data. A write with strobe
// bit zero clear still completes with an OKAY response but leaves
// the register untouched. Unmapped or misaligned addresses answer
// SLVERR and change nothing.
//
// Read channel behaviour:
// The read address is taken whenever no read data is pending, and
// the data is registered on the same edge. Read data therefore
// comes one cycle after the address is taken and stands until the
// master's ready is seen high. A read has no side effect on any
// register or flag. Unmapped reads answer SLVERR with zero data; a
// misaligned read answers SLVERR but returns the addressed register's byte.
//
// Default loading:
// After reset is released the loader copies the configuration
// defaults into all four registers once. A later load request,
// seen while the loader is idle in its done state, repeats the
// copy. A load overrides a bus write that lands in the same cycle;
// software should wait for the loaded flag before its first write.
// The printed reset values hold only until that first load.
//
// Decoded outputs:
// Both converters share one decoder module. Its outputs are purely
// combinational from the stored registers, so a new current limit
// reaches the converter in the cycle after the write lands, even
// while the converter is running.
//
// Limitations:
// At most two writes and one read are in flight at a time. There is no
// write-to-read ordering between the two channels: a read issued
// in the same cycle as a write completes may see the old value.
// No interrupt, no parity and no lock of any register is provided.
`timescale 1ns/10ps
`default_nettype none
module csr_regs (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Defaults from configuration memory, sampled on load.
    input wire logic otp_load,
    input wire csr_pkg::csr_defaults_t otp_defaults,
    // AXI4-Lite write address channel.
    input wire logic [5:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data channel.
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response channel.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address channel.
    input wire logic [5:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data channel.
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Decoded setpoints driving the analogue converters.
    output csr_pkg::csr_setpoint_t conv0_setpoint,
    output csr_pkg::csr_setpoint_t conv1_setpoint,
    // High once defaults have been loaded.
    output logic defaults_loaded
);
    import csr_pkg::*;

    // Map a byte address to a register index check.
    function automatic logic [4:0] decode_idx(input logic [5:0] addr);
        logic [3:0] idx;
        idx = addr[5:2];
        decode_idx = {idx == CSR_IDX_CONV0_CTRL, idx == CSR_IDX_CONV1_CTRL,
            idx == CSR_IDX_CONV0_VSET, idx == CSR_IDX_CONV1_VSET,
            addr[1:0] == 2'h0};
    endfunction

    // Stored register values.
    logic [7:0] conv0_ctrl;
    logic [7:0] conv1_ctrl;
    logic [7:0] conv0_vset;
    logic [7:0] conv1_vset;
    // Captured write address and data, each with its own hold flag.
    logic [5:0] aw_addr;
    logic aw_held;
    logic [7:0] w_byte;
    logic w_lane0;
    logic w_held;
    // Loader state.
    csr_ld_state_t ld_state;
    csr_ld_state_t next_ld_state;

    // Write path: both halves present and no response pending.
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire [4:0] wdec = decode_idx(aw_addr);
    wire w_hit = wdec[0] && (wdec[4] | wdec[3] | wdec[2] | wdec[1]);
    // Only byte lane zero carries data; other lanes read as zero.
    wire w_en = do_write && w_hit && w_lane0;
    wire we_c0 = w_en && wdec[4];
    wire we_c1 = w_en && wdec[3];
    wire we_v0 = w_en && wdec[2];
    wire we_v1 = w_en && wdec[1];
    // Load of defaults takes priority over a bus write in the same cycle.
    wire ld_now = ld_state == CSR_LD_LOAD;

    // Read path.
    wire rd_take = s_axi_arvalid && s_axi_arready;
    wire [4:0] rdec = decode_idx(s_axi_araddr);
    wire r_hit = rdec[0] && (rdec[4] | rdec[3] | rdec[2] | rdec[1]);
    wire [7:0] r_byte = rdec[4] ? conv0_ctrl :
        rdec[3] ? conv1_ctrl :
        rdec[2] ? conv0_vset :
        rdec[1] ? conv1_vset : 8'h00;

    // Channel readies: accept a half while its hold slot is free.
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;
    assign s_axi_arready = !s_axi_rvalid;

    // Loader: one load after reset, and again on each request.
    always_comb begin
        next_ld_state = ld_state;
        case (ld_state)
            CSR_LD_IDLE: begin
                next_ld_state = CSR_LD_LOAD;
            end
            CSR_LD_LOAD: begin
                next_ld_state = CSR_LD_DONE;
            end
            CSR_LD_DONE: begin
                if (otp_load) begin
                    next_ld_state = CSR_LD_LOAD;
                end
            end
            default: begin
                next_ld_state = CSR_LD_IDLE;
            end
        endcase
    end

    // Loader state register.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ld_state <= CSR_LD_IDLE;
        end else begin
            ld_state <= next_ld_state;
        end
    end
    assign defaults_loaded = ld_state == CSR_LD_DONE;

    // Converter a control register, reserved bits kept as written.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv0_ctrl <= CSR_CTRL_RESET;
        end else if (ld_now) begin
            conv0_ctrl <= otp_defaults.conv0_ctrl;
        end else if (we_c0) begin
            conv0_ctrl <= w_byte;
        end
    end

    // Converter b control; a write lands at once, even while running.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv1_ctrl <= CSR_CTRL_RESET;
        end else if (ld_now) begin
            conv1_ctrl <= otp_defaults.conv1_ctrl;
        end else if (we_c1) begin
            conv1_ctrl <= w_byte;
        end
    end

    // Voltage set registers. Reserved low codes are stored as written,
    // since keeping them out is the host's duty; the decoder flags them.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            conv0_vset <= CSR_VSET_RESET;
            conv1_vset <= CSR_VSET_RESET;
        end else if (ld_now) begin
            conv0_vset <= otp_defaults.conv0_vset;
            conv1_vset <= otp_defaults.conv1_vset;
        end else begin
            if (we_v0) begin
                conv0_vset <= w_byte;
            end
            if (we_v1) begin
                conv1_vset <= w_byte;
            end
        end
    end

    // Write address capture.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 6'h00;
        end else if (s_axi_awvalid && !aw_held) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    // Write data capture; only the low byte matters.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_byte <= 8'h00;
            w_lane0 <= 1'b0;
        end else if (s_axi_wvalid && !w_held) begin
            w_held <= 1'b1;
            w_byte <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    // Write response: unmapped or misaligned addresses get SLVERR.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= CSR_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= w_hit ? CSR_RESP_OKAY : CSR_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read response; a read changes no state besides its own handshake.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= CSR_RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, r_byte};
            s_axi_rresp <= r_hit ? CSR_RESP_OKAY : CSR_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Decoders for both converters share one module.
    csr_decode u_dec0 (
        .ctrl(conv0_ctrl),
        .vset(conv0_vset),
        .setpoint(conv0_setpoint)
    );
    csr_decode u_dec1 (
        .ctrl(conv1_ctrl),
        .vset(conv1_vset),
        .setpoint(conv1_setpoint)
    );
endmodule // csr_regs
`default_nettype wire

// >>> tb/csr_regs_chk.sv
// Checker of bus handshakes and setpoint decoding for the register bank.
`timescale 1ns/10ps
`default_nettype none
module csr_regs_chk (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Write channels.
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read channels.
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Decoded setpoint of converter b.
    input wire csr_pkg::csr_setpoint_t conv1_setpoint
);
    import csr_pkg::*;
    // One clock domain, so reset masks every check at once.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid) else $error("Read not answered next cycle.");
    a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("Read address taken while data pending.");
    a_b_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("Write not answered in time.");
    a_rdata_pad: assert property (s_axi_rvalid |->
        s_axi_rdata[31:8] == 24'h0) else $error("Upper read bits set.");
    a_ilim_range: assert property (conv1_setpoint.ilim_valid |->
        conv1_setpoint.ilim_ma inside {[13'h05dc:13'h1194]} &&
        (conv1_setpoint.ilim_ma - 13'h05dc) % 13'h01f4 == 13'h0)
        else $error("Current limit off the 0.5 A grid.");
    a_slew_valid: assert property (conv1_setpoint.slew_valid ==
        (conv1_setpoint.slew_code >= 3'h2)) else $error("Slew flag wrong.");
    a_vout_range: assert property (conv1_setpoint.vout_valid |->
        conv1_setpoint.vout_mv inside {[12'h2bc:12'hd20]})
        else $error("Output target out of range.");
endmodule // csr_regs_chk
bind csr_regs csr_regs_chk u_csr_regs_chk (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .conv1_setpoint(conv1_setpoint)
);
`default_nettype wire

// >>> tb/csr_regs_tb.sv
// Self-checking bench of the converter setpoint register bank.
`timescale 1ns/10ps
`default_nettype none
module csr_regs_tb;
    import csr_pkg::*;
    // Clock, reset, defaults and bus; responses are accepted at once unless a task stalls them.
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic otp_load = 1'b0;
    csr_defaults_t otp_defaults = {8'h2c, 8'h33, 8'h9e, 8'hff};
    logic [5:0] s_axi_awaddr = 6'h0, s_axi_araddr = 6'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, defaults_loaded;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    csr_setpoint_t conv0_setpoint, conv1_setpoint;
    int n_mismatch = 0, compares = 0, cycles = 0;
    // Byte addresses are the register indices times four.
    localparam logic [5:0] A_C0 = {CSR_IDX_CONV0_CTRL, 2'b00};
    localparam logic [5:0] A_C1 = {CSR_IDX_CONV1_CTRL, 2'b00};
    localparam logic [5:0] A_V0 = {CSR_IDX_CONV0_VSET, 2'b00};
    localparam logic [5:0] A_V1 = {CSR_IDX_CONV1_VSET, 2'b00};
    csr_regs u_csr_regs (.*);
    always #10 aclk = ~aclk;
    // The run takes under 200 cycles, so 5000 means a hang.
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    task give_verdict();
        $display("Mismatches %0d, comparisons %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] exp, got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Handshakes are judged at the rising edge; a stall holds the
    // response ready low for that many cycles after the answer shows.
    task wr(input logic [5:0] a, input logic [7:0] d, input logic [3:0] s,
            input logic [1:0] er, input int stall = 0);
        logic done;
        logic [1:0] rs;
        int n;
        done = 1'b0;
        rs = 2'h0;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= (stall == 0);
        while (!done) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                done = 1'b1;
                rs = s_axi_bresp;
            end else if (s_axi_bvalid) begin
                n++;
                if (n >= stall) s_axi_bready <= 1'b1;
            end
        end
        chk("bresp", {30'h0, er}, {30'h0, rs});
    endtask
    task rd(input logic [5:0] a, input logic [31:0] ed, input logic [1:0] er,
            input int stall = 0);
        logic done;
        logic [31:0] dv;
        logic [1:0] rs;
        int n;
        done = 1'b0;
        dv = 32'h0;
        rs = 2'h0;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= (stall == 0);
        while (!done) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) begin
                done = 1'b1;
                dv = s_axi_rdata;
                rs = s_axi_rresp;
            end else if (s_axi_rvalid) begin
                n++;
                if (n >= stall) s_axi_rready <= 1'b1;
            end
        end
        chk("rdata", ed, dv);
        chk("rresp", {30'h0, er}, {30'h0, rs});
    endtask
    // Codes below 0x14 are never written by the host.
    logic [7:0] codes [6] = '{8'h14, 8'h17, 8'h18, 8'h9d, 8'h9e, 8'hff};
    logic [11:0] mv [6] = '{12'h2bc, 12'h2da, 12'h2df, 12'h578, 12'h58c, 12'hd20};
    logic [7:0] d;
    initial begin
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        chk("rst ilim", 32'hbb8, {19'h0, conv1_setpoint.ilim_ma});
        chk("rst slew", 32'h2, {29'h0, conv1_setpoint.slew_code});
        chk("rst vset", 32'h0, {31'h0, conv0_setpoint.vout_valid});
        @(posedge aclk);
        aresetn <= 1'b1;
        while (defaults_loaded !== 1'b1) @(posedge aclk);
        rd(A_C0, 32'h2c, CSR_RESP_OKAY);
        rd(A_C1, 32'h33, CSR_RESP_OKAY);
        rd(A_V0, 32'h9e, CSR_RESP_OKAY);
        rd(A_V1, 32'hff, CSR_RESP_OKAY);
        // Every current and slew code, reserved bits toggled too.
        for (int c = 0; c < 8; c++) begin
            d = {c[1:0], c[2:0], c[2:0]};
            wr(A_C1, d, 4'hf, CSR_RESP_OKAY);
            @(negedge aclk);
            chk("ilim ok", c != 7, {31'h0, conv1_setpoint.ilim_valid});
            if (c != 7) chk("ilim", 32'h5dc + 32'h1f4 * c,
                {19'h0, conv1_setpoint.ilim_ma});
            chk("slew ok", c >= 2, {31'h0, conv1_setpoint.slew_valid});
            chk("slew", c, {29'h0, conv1_setpoint.slew_code});
            rd(A_C1, {24'h0, d}, CSR_RESP_OKAY);
        end
        // Segment edges of the voltage code, both converters at once.
        for (int i = 0; i < 6; i++) begin
            wr(A_V0, codes[i], 4'hf, CSR_RESP_OKAY);
            wr(A_V1, codes[5 - i], 4'hf, CSR_RESP_OKAY);
            @(negedge aclk);
            chk("vout a", {19'h1, mv[i]}, {19'h0, conv0_setpoint.vout_valid,
                conv0_setpoint.vout_mv});
            chk("vout b", {19'h1, mv[5 - i]}, {19'h0, conv1_setpoint.vout_valid,
                conv1_setpoint.vout_mv});
        end
        // Refused and masked writes leave the registers alone.
        wr(6'h20, 8'h55, 4'hf, CSR_RESP_SLVERR);
        wr(A_C1 + 6'h1, 8'h00, 4'hf, CSR_RESP_SLVERR);
        wr(A_V1, 8'h20, 4'h0, CSR_RESP_OKAY, 2);
        rd(6'h20, 32'h0, CSR_RESP_SLVERR);
        rd(A_C1, 32'hff, CSR_RESP_OKAY);
        rd(A_V1, 32'h14, CSR_RESP_OKAY, 2);
        // A reload request brings in a fresh set of defaults.
        otp_defaults <= {8'h1a, 8'h21, 8'h14, 8'h18};
        otp_load <= 1'b1;
        @(posedge aclk);
        otp_load <= 1'b0;
        repeat (3) @(posedge aclk);
        rd(A_C1, 32'h21, CSR_RESP_OKAY);
        rd(A_V1, 32'h18, CSR_RESP_OKAY);
        give_verdict();
    end
endmodule // csr_regs_tb
`default_nettype wire
